// ---- core/sstfb_pkg.sv ----
// ****************************************************************
// Shared constants of the safety status feedback block.
// ****************************************************************
package sstfb_pkg;
    // Clock and zone poll timing.
    localparam int CLK_NS     = 4;
    localparam int SETTLE_NS  = 20;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ZID_W      = 4;
    localparam int DATA_W     = 32;
    localparam int AW         = 8;
    localparam int PIN_W      = 8;
    localparam int IRQ_W      = 3;

    // Register byte addresses.
    localparam logic [AW-1:0] REG_CTRL    = 8'h00;
    localparam logic [AW-1:0] REG_STAT    = 8'h04;
    localparam logic [AW-1:0] REG_IRQ_ST  = 8'h08;
    localparam logic [AW-1:0] REG_IRQ_CLR = 8'h0C;
    localparam logic [AW-1:0] REG_IRQ_EN  = 8'h10;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;

    // Control register fields.
    localparam int C_GUARD  = 0;
    localparam int C_MASTER = 1;
    localparam int C_SLAVE  = 2;
    localparam int C_PARAM  = 3;
    localparam int C_FBUS   = 4;
    localparam int C_ACTIVE = 5;
    localparam int C_NSLV   = 8;
    localparam int C_ID     = 12;

    // Status register fields.
    localparam int S_SAFE  = 0;
    localparam int S_CH1   = 1;
    localparam int S_CH2   = 2;
    localparam int S_CH2OE = 3;
    localparam int S_ZONE  = 4;
    localparam int S_GLMON = 5;
    localparam int S_ENC   = 6;
    localparam int S_GL    = 7;

    // Interrupt status fields.
    localparam int I_ACKERR = 0;
    localparam int I_ENC    = 1;
    localparam int I_SAFE   = 2;

    typedef enum logic [2:0]
    {
        P_IDLE   = 3'b001,
        P_WAIT   = 3'b010,
        P_SAMPLE = 3'b100
    } sstfb_poll_t;
endpackage : sstfb_pkg

// ---- core/sstfb_zone_if.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Link between the core and the zone poller.
// ****************************************************************
interface sstfb_zone_if;
    logic                     enable;
    logic [sstfb_pkg::ZID_W-1:0] nslv;
    logic                     ack_in;
    logic                     active_in;
    logic                     all_safe;
    logic                     ack_err;
    logic [sstfb_pkg::ZID_W-1:0] sel;
    logic                     poll;
    modport ctl    (output enable, nslv, ack_in, active_in,
                    input all_safe, ack_err, sel, poll);
    modport poller (input enable, nslv, ack_in, active_in,
                    output all_safe, ack_err, sel, poll);
endinterface : sstfb_zone_if

// ---- core/sstfb_poll.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Zone master poller: walks the slaves and gathers their answers.
// ****************************************************************
module sstfb_poll
    import sstfb_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Zone link.
    sstfb_zone_if.poller zif
);
    sstfb_poll_t      state;
    logic [ZID_W-1:0] idx;
    logic [3:0]       cnt;
    logic             acc_safe;
    logic             acc_act;
    logic             last_safe;
    logic             last_act;

    // Answer of the slave sampled now, folded into the round.
    assign last_safe = acc_safe & zif.ack_in;
    assign last_act  = acc_act & zif.active_in;

    // One round addresses every slave, waits out the pin
    // synchronisers and only then samples; a round result is published
    // as a whole so a slave dropping out mid-round is never masked.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state        <= P_IDLE;
            idx          <= '0;
            cnt          <= '0;
            acc_safe     <= 1'b1;
            acc_act      <= 1'b1;
            zif.all_safe <= 1'b0;
            zif.ack_err  <= 1'b0;
            zif.sel      <= '0;
            zif.poll     <= 1'b0;
        end
        else
        begin
            zif.ack_err <= 1'b0;
            unique case (state)
                P_IDLE:
                begin
                    acc_safe <= 1'b1;
                    acc_act  <= 1'b1;
                    if (!zif.enable)
                    begin
                        zif.all_safe <= 1'b0;
                    end
                    else if (zif.nslv == '0)
                    begin
                        zif.all_safe <= 1'b1;
                    end
                    else
                    begin
                        idx      <= ZID_W'(1);
                        zif.sel  <= ZID_W'(1);
                        zif.poll <= 1'b1;
                        cnt      <= 4'(SETTLE_CYC);
                        state    <= P_WAIT;
                    end
                end
                P_WAIT:
                begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h1)
                    begin
                        state <= P_SAMPLE;
                    end
                end
                P_SAMPLE:
                begin
                    acc_safe <= last_safe;
                    acc_act  <= last_act;
                    zif.poll <= 1'b0;
                    if (idx >= zif.nslv || !zif.enable)
                    begin
                        zif.all_safe <= last_safe & last_act & zif.enable;
                        zif.ack_err  <= ~last_act & zif.enable;
                        state        <= P_IDLE;
                    end
                    else
                    begin
                        idx      <= idx + ZID_W'(1);
                        zif.sel  <= idx + ZID_W'(1);
                        zif.poll <= 1'b1;
                        cnt      <= 4'(SETTLE_CYC);
                        state    <= P_WAIT;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    sequence s_last_dead;
        state == P_SAMPLE && idx >= zif.nslv && zif.enable && !last_act;
    endsequence
    property p_ack_err;
        @(posedge clk) disable iff (!rst_n)
        s_last_dead |=> zif.ack_err && !zif.all_safe;
    endproperty
    a_ack_err: assert property (p_ack_err)
        else $error("Inactive slave did not raise the check error.");
endmodule : sstfb_poll

// ---- core/sstfb_out.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Dual-channel status output stage with parameter mode hold.
// ****************************************************************
module sstfb_out
    import sstfb_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Decided state.
    input  wire logic safe,
    input  wire logic enc_fault,
    input  wire logic gl,
    input  wire logic param,
    input  wire logic master,
    input  wire logic slave,
    // Channels.
    output logic      ch1,
    output logic      ch2_o,
    output logic      ch2_oe
);
    logic [2:0] snap;
    logic [2:0] next_out;
    logic       hold;

    assign hold = param & (slave | gl);

    // Pattern choice; an encoder fault overrides even a held safe state.
    always_comb
    begin
        if (hold)
        begin
            next_out = snap;
        end
        else if (safe && !param)
        begin
            next_out = 3'b101;
        end
        else if (gl)
        begin
            next_out = 3'b000;
        end
        else
        begin
            next_out = 3'b011;
        end
        if (enc_fault && next_out[2])
        begin
            next_out = gl ? 3'b000 : 3'b011;
        end
    end

    // Outputs and snapshot; the snapshot freezes on entry to parameter mode.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {ch1, ch2_o, ch2_oe} <= 3'b011;
            snap                 <= 3'b011;
        end
        else
        begin
            {ch1, ch2_o, ch2_oe} <= next_out;
            if (!param)
            begin
                snap <= next_out;
            end
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_safe_pat;
        @(posedge clk) disable iff (!rst_n)
        safe && !param && !enc_fault |=> ch1 && !ch2_o && ch2_oe;
    endproperty
    a_safe_pat: assert property (p_safe_pat)
        else $error("Safe pattern not driven.");
    property p_enc;
        @(posedge clk) disable iff (!rst_n)
        enc_fault |=> !ch1;
    endproperty
    a_enc: assert property (p_enc)
        else $error("Safe reported during encoder fault.");
    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (hold && !enc_fault)[*2] |=> $stable({ch1, ch2_o, ch2_oe});
    endproperty
    a_hold: assert property (p_hold)
        else $error("Outputs moved in parameter mode hold.");
    property p_master_param;
        @(posedge clk) disable iff (!rst_n)
        param && master && !gl |=> !ch1 && ch2_o && ch2_oe;
    endproperty
    a_master_param: assert property (p_master_param)
        else $error("Master in parameter mode not reporting unsafe.");
    property p_gl_float;
        @(posedge clk) disable iff (!rst_n)
        gl && !param && !safe |=> !ch1 && !ch2_oe;
    endproperty
    a_gl_float: assert property (p_gl_float)
        else $error("Guard lock channel two not released.");
endmodule : sstfb_out

// ---- core/sstfb_core.sv ----
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - PLC variant: safe high/low, else low/high
// - Zone slave or guard lock: hold outputs; held only in parameter mode
// - Guard lock: unsafe releases channel two
// - Guard lock only allowed for zone master
// - Fieldbus selection: no dynamization, no guard lock
// - Channel two switches low when asserted
// - Master polls each slave for acknowledgment
// - Master safe only when all axes safe
// - Inactive slave raises acknowledgment check error
// - Encoder fault never reports safe state
module sstfb_core
    import sstfb_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Register port.
    input  wire logic [AW-1:0]     reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   irq,
    // Own axis state from the motion monitor.
    input  wire logic              axis_safe,
    input  wire logic              encoder_fault,
    // Guard lock monitor pin.
    input  wire logic              guard_lock_monitor_in,
    // Status output channels.
    output logic                   safe_status_out_ch1,
    output logic                   safe_status_out_ch2_o,
    output logic                   safe_status_out_ch2_oe,
    // Zone bus, master side.
    output logic      [ZID_W-1:0]  zone_sel_out,
    output logic                   zone_poll_out,
    input  wire logic              zone_ack_bus_in,
    input  wire logic              zone_active_in,
    // Zone bus, slave side.
    input  wire logic [ZID_W-1:0]  zone_sel_in,
    input  wire logic              zone_poll_in,
    output logic                   zone_ack_bus_o,
    output logic                   zone_ack_bus_oe,
    output logic                   zone_active_o,
    output logic                   zone_active_oe
);
    // ****************************************************************
    // Reset and pin synchronisers.
    // ****************************************************************
    logic             rst_meta;
    logic             rst_n;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic             glmon_s;
    logic             ack_s;
    logic             act_s;
    logic             poll_s;
    logic [ZID_W-1:0] sel_s;

    // Reset is released through two flops so no flop sees a ragged edge.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // The guard lock monitor and zone bus pins pass two flops before any logic looks at them.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {guard_lock_monitor_in, zone_ack_bus_in,
                         zone_active_in, zone_poll_in, zone_sel_in};
            pin_sync <= pin_meta;
        end
    end

    assign {glmon_s, ack_s, act_s, poll_s, sel_s} = pin_sync;

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [DATA_W-1:0] ctrl;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_en;
    logic [IRQ_W-1:0]  irq_ev;
    logic [DATA_W-1:0] stat;

    // Control word and interrupt enable writes.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl   <= CTRL_RST;
            irq_en <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == REG_CTRL)
            begin
                ctrl <= reg_wdata;
            end
            if (reg_addr == REG_IRQ_EN)
            begin
                irq_en <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Configuration decode.
    // ****************************************************************
    logic             is_slave;
    logic             is_master;
    logic             cfg_param;
    logic             cfg_fbus;
    logic             cfg_active;
    logic             gl_eff;
    logic [ZID_W-1:0] cfg_nslv;
    logic [ZID_W-1:0] cfg_id;

    // A drive set both ways is taken as a slave, so a zone misconfigured
    // with two masters still ends up with at most one driving its output.
    assign is_slave   = ctrl[C_SLAVE];
    assign is_master  = ctrl[C_MASTER] & ~ctrl[C_SLAVE];
    assign cfg_param  = ctrl[C_PARAM];
    assign cfg_fbus   = ctrl[C_FBUS];
    assign cfg_active = ctrl[C_ACTIVE];
    assign cfg_nslv   = ctrl[C_NSLV +: ZID_W];
    assign cfg_id     = ctrl[C_ID +: ZID_W];

    // Guard lock drive needs the master role and no fieldbus selection;
    // the outputs are plain levels, never test-pulsed, in every mode.
    assign gl_eff = ctrl[C_GUARD] & is_master & ~cfg_fbus;

    // ****************************************************************
    // Zone polling.
    // ****************************************************************
    sstfb_zone_if zif ();
    logic safe_core;

    assign zif.enable    = is_master & cfg_active & ~cfg_param;
    assign zif.nslv      = cfg_nslv;
    assign zif.ack_in    = ack_s;
    assign zif.active_in = act_s;
    assign zone_sel_out  = zif.sel;
    assign zone_poll_out = zif.poll;

    sstfb_poll u_poll
    (
        .clk   (clk),
        .rst_n (rst_n),
        .zif   (zif.poller)
    );

    // Own axis must be safe and healthy; a master also needs every slave.
    assign safe_core = axis_safe & ~encoder_fault & cfg_active
                     & (~is_master | zif.all_safe);

    // Slave answers only while addressed, otherwise it releases the line.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zone_ack_bus_o  <= 1'b0;
            zone_ack_bus_oe <= 1'b0;
            zone_active_o   <= 1'b0;
            zone_active_oe  <= 1'b0;
        end
        else
        begin
            zone_ack_bus_oe <= is_slave & poll_s & (sel_s == cfg_id);
            zone_active_oe  <= is_slave & poll_s & (sel_s == cfg_id);
            zone_ack_bus_o  <= safe_core;
            zone_active_o   <= cfg_active;
        end
    end

    // ****************************************************************
    // Output stage.
    // ****************************************************************
    sstfb_out u_out
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .safe      (safe_core),
        .enc_fault (encoder_fault),
        .gl        (gl_eff),
        .param     (cfg_param),
        .master    (is_master),
        .slave     (is_slave),
        .ch1       (safe_status_out_ch1),
        .ch2_o     (safe_status_out_ch2_o),
        .ch2_oe    (safe_status_out_ch2_oe)
    );

    // ****************************************************************
    // Interrupts and read back.
    // ****************************************************************
    logic zone_ack_check_error;
    logic enc_d;
    logic ch1_d;

    assign zone_ack_check_error = zif.ack_err;

    // Edge history for the encoder and safe-state change events.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enc_d <= 1'b0;
            ch1_d <= 1'b0;
        end
        else
        begin
            enc_d <= encoder_fault;
            ch1_d <= safe_status_out_ch1;
        end
    end

    assign irq_ev[I_ACKERR] = zone_ack_check_error;
    assign irq_ev[I_ENC]    = encoder_fault & ~enc_d;
    assign irq_ev[I_SAFE]   = safe_status_out_ch1 ^ ch1_d;

    // A new event wins over a clear written in the same cycle.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_st <= '0;
        end
        else if (reg_wr && reg_addr == REG_IRQ_CLR)
        begin
            irq_st <= (irq_st & ~reg_wdata[IRQ_W-1:0]) | irq_ev;
        end
        else
        begin
            irq_st <= irq_st | irq_ev;
        end
    end

    assign irq = |(irq_st & irq_en);

    // Live state; the monitor input is forwarded by the controller.
    always_comb
    begin
        stat          = '0;
        stat[S_SAFE]  = safe_core;
        stat[S_CH1]   = safe_status_out_ch1;
        stat[S_CH2]   = safe_status_out_ch2_o;
        stat[S_CH2OE] = safe_status_out_ch2_oe;
        stat[S_ZONE]  = zif.all_safe;
        stat[S_GLMON] = glmon_s;
        stat[S_ENC]   = encoder_fault;
        stat[S_GL]    = gl_eff;
    end

    // Read data stand one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL:   reg_rdata <= ctrl;
                REG_STAT:   reg_rdata <= stat;
                REG_IRQ_ST: reg_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_st};
                REG_IRQ_EN: reg_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_en};
                default:    reg_rdata <= '0;
            endcase
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_gl_master;
        @(posedge clk) disable iff (!rst_n)
        !is_master && !cfg_param |=> safe_status_out_ch2_oe;
    endproperty
    a_gl_master: assert property (p_gl_master)
        else $error("Guard lock enabled outside master role.");
    property p_fbus;
        @(posedge clk) disable iff (!rst_n)
        cfg_fbus && !cfg_param |=> safe_status_out_ch2_oe;
    endproperty
    a_fbus: assert property (p_fbus)
        else $error("Guard lock release under fieldbus selection.");
    property p_zone_safe;
        @(posedge clk) disable iff (!rst_n)
        is_master && !cfg_param && $rose(safe_status_out_ch1)
            |-> $past(zif.all_safe) && $past(axis_safe);
    endproperty
    a_zone_safe: assert property (p_zone_safe)
        else $error("Master reported safe without all axes.");
    property p_irq_err;
        @(posedge clk) disable iff (!rst_n)
        zone_ack_check_error && irq_en[I_ACKERR] |=> irq ##0 irq_st[I_ACKERR];
    endproperty
    a_irq_err: assert property (p_irq_err)
        else $error("Check error did not reach the interrupt.");
endmodule : sstfb_core

// ---- sim/sstfb_zone_slaves.sv ----
`timescale 1ns/1ns
// ****
// Zone slaves as seen from the master.
// ****
module sstfb_zone_slaves
(
    // Clock.
    input  wire logic        clk,
    // Master address.
    input  wire logic [3:0]  sel,
    input  wire logic        poll,
    // Slave states.
    input  wire logic [15:0] slv_safe,
    input  wire logic [15:0] slv_active,
    // Answer pins.
    output logic             ack = 1'b0,
    output logic             active = 1'b0
);
    // Only the addressed slave answers; idle lines toggle so stale data never passes.
    always @(posedge clk)
    begin
        ack    <= poll ? slv_safe[sel] : ~ack;
        active <= poll ? slv_active[sel] : ~active;
    end
endmodule : sstfb_zone_slaves

// ---- sim/safety_status_feedback_tb.sv ----
`timescale 1ns/1ns
// ****
// Bench of the safety status feedback block.
// ****
module safety_status_feedback_tb;
    import sstfb_pkg::*;
    logic              clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic [AW-1:0]     reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, v;
    logic              irq, axis_safe = 0, enc = 0, glm = 0, ch1, ch2_o, ch2_oe;
    logic [ZID_W-1:0]  zsel_o, zsel_i = '0;
    logic              zpoll_o, zpoll_i = 0, ack, act, ack_o, ack_oe, act_o, act_oe;
    logic [15:0]       slv_safe = 16'hFFFF, slv_active = 16'hFFFF;
    int                fails = 0, checks_done = 0;
    logic              s, e;

    // Clock at 250 MHz.
    always #2 clk = ~clk;

    sstfb_core u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .axis_safe(axis_safe), .encoder_fault(enc),
        .guard_lock_monitor_in(glm), .safe_status_out_ch1(ch1),
        .safe_status_out_ch2_o(ch2_o), .safe_status_out_ch2_oe(ch2_oe),
        .zone_sel_out(zsel_o), .zone_poll_out(zpoll_o), .zone_ack_bus_in(ack),
        .zone_active_in(act), .zone_sel_in(zsel_i), .zone_poll_in(zpoll_i),
        .zone_ack_bus_o(ack_o), .zone_ack_bus_oe(ack_oe), .zone_active_o(act_o),
        .zone_active_oe(act_oe));

    sstfb_zone_slaves u_slv (.clk(clk), .sel(zsel_o), .poll(zpoll_o),
        .slv_safe(slv_safe), .slv_active(slv_active), .ack(ack), .active(act));

    // Expected channels {ch1, ch2_o, ch2_oe}; guard lock releases channel two.
    function automatic logic [2:0] f_out(input logic sf, input logic glk);
        return sf ? 3'b101 : (glk ? 3'b000 : 3'b011);
    endfunction : f_out

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // Writes the control word and own axis state, then lets the channels settle.
    task automatic cfg(input logic [31:0] c, input logic sf);
        wr(REG_CTRL, c);
        axis_safe <= sf;
        repeat (4) @(posedge clk);
        #1;
    endtask : cfg

    // Bounded wait on ch1 or irq; a zone round lasts several slave slots.
    task automatic wt(input bit use_irq, input logic x);
        int n;
        for (n = 0; n < 300 && (use_irq ? irq : ch1) !== x; n++)
        begin
            @(posedge clk);
            #1;
        end
        chk("wait", 32'(n < 300), 1);
    endtask : wt

    task automatic conclude;
        $display("Checks %0d, errors %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // Watchdog against a hang.
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        conclude;
    end

    // Main sequence.
    initial
    begin
        void'($urandom(32'h2CEE));
        repeat (20) @(posedge clk);
        chk("rst_out", {ch1, ch2_o, ch2_oe}, 3'b011);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(REG_CTRL);
        chk("ctrl_rst", v, CTRL_RST);
        rd(8'h40);
        chk("unmapped", v, 0);
        wr(REG_IRQ_EN, 32'h7);
        for (int i = 0; i < 24; i++)
        begin
            s = 1'($urandom);
            e = 1'(($urandom % 4) == 0);
            enc <= e;
            cfg(32'h20, s);
            chk("plc", {ch1, ch2_o, ch2_oe}, f_out(s & !e, 0));
        end
        enc <= 1'b0;
        cfg(32'h20, 1);
        wr(REG_IRQ_CLR, 32'h7);
        enc <= 1'b1;
        repeat (4) @(posedge clk);
        rd(REG_IRQ_ST);
        chk("irq_st", v, 32'h6);
        chk("irq", irq, 1);
        wr(REG_IRQ_EN, 0);
        #1 chk("irq_mask", irq, 0);
        wr(REG_IRQ_CLR, 32'h7);
        rd(REG_IRQ_ST);
        chk("irq_clr", v, 0);
        enc <= 1'b0;
        cfg(32'h21, 0);
        chk("gl_nomaster", {ch1, ch2_o, ch2_oe}, 3'b011);
        cfg(32'h33, 0);
        chk("gl_fbus", {ch1, ch2_o, ch2_oe}, 3'b011);
        cfg(32'h23, 0);
        chk("gl_unsafe", {ch1, ch2_o, ch2_oe}, f_out(0, 1));
        cfg(32'h23, 1);
        chk("gl_safe", {ch1, ch2_o, ch2_oe}, f_out(1, 1));
        cfg(32'h2B, 0);
        chk("gl_hold", {ch1, ch2_o, ch2_oe}, 3'b101);
        enc <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("hold_enc", ch1, 0);
        enc <= 1'b0;
        cfg(32'h2A, 1);
        chk("par_master", {ch1, ch2_o, ch2_oe}, 3'b011);
        cfg(32'h3024, 1);
        zsel_i  <= 4'h3;
        zpoll_i <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("slv_answer", {ack_oe, ack_o, act_oe, act_o}, 4'hF);
        cfg(32'h302C, 0);
        chk("slv_hold", {ch1, ch2_o, ch2_oe}, 3'b101);
        zpoll_i <= 1'b0;
        // A single master polling two slaves in this zone.
        cfg(32'h222, 1);
        wt(0, 1);
        rd(REG_STAT);
        chk("zone_all", v[S_ZONE], 1);
        slv_safe[2] <= 1'b0;
        wt(0, 0);
        slv_safe[2]   <= 1'b1;
        slv_active[1] <= 1'b0;
        wr(REG_IRQ_CLR, 32'h7);
        wr(REG_IRQ_EN, 32'h1);
        wt(1, 1);
        glm <= 1'b1;
        repeat (4) @(posedge clk);
        rd(REG_STAT);
        chk("glmon", v[S_GLMON], 1);
        conclude;
    end
endmodule : safety_status_feedback_tb
